/* seq_pkg.sv */
// Purpose: Shared constants for the line controlled set sequencer
// Assumes: 25 MHz mclk, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned 32-bit words
package seq_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_COUNT    = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_BASE     = 8'h0C;
    localparam logic [7:0] ADDR_SET_SEL  = 8'h10;
    localparam logic [7:0] ADDR_SET_DATA = 8'h14;
    localparam logic [7:0] ADDR_ACTIVE   = 8'h18;

    // ----------------------------------------------------------------
    // Control field layout and reset values
    // ----------------------------------------------------------------
    localparam int          CTRL_W       = 12;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_ADV_LSB = 1;
    localparam int          CTRL_RST_LSB = 3;
    localparam int          CTRL_REN_BIT = 5;
    localparam int          CTRL_INV_LSB = 8;
    localparam logic [11:0] CTRL_RST     = 12'h000;
    localparam int          STAT_IDX_LSB = 8;
    localparam int          COUNT_RST    = 6;

    // Control line choices, identical in behaviour
    typedef enum logic [1:0] {
        LINE_OPT    = 2'b00,
        LINE_HOST_A = 2'b01,
        LINE_HOST_B = 2'b10,
        LINE_HOST_C = 2'b11
    } line_sel_type;

    // Pin vector positions after synchronising
    localparam int PIN_TRIG = 4;
    localparam int PIN_N    = 5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_NS     = 1000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* line_sync.sv */
// Purpose: Three stage synchroniser for a group of pins
// Assumes: Pins are asynchronous to mclk
// Notes:   A new level counts once stages two and three agree
`timescale 1ns/1ps
module line_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Pins and synchronised view
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] change
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;
    logic [WIDTH-1:0] next_change;

    // Accept a level only when the two late stages agree
    always_comb begin
        next_level  = level;
        next_change = '0;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i] && stage3[i] != level[i]) begin
                next_level[i]  = stage3[i];
                next_change[i] = 1'b1;
            end
        end
    end

    // Stage one feeds stage two only, to keep metastability contained
    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level  <= '0;
            change <= '0;
        end else begin
            stage1 <= pins;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
            change <= next_change;
        end
    end
endmodule // line_sync

/* set_store.sv */
// Purpose: Storage for the stored parameter sets
// Assumes: One write port from software, one read port for loading
// Notes:   Read is combinational so a load lands in one cycle
`timescale 1ns/1ps
module set_store #(
    parameter int DATA_W = 32,
    parameter int SETS   = 64,
    parameter int IDX_W  = 6
) (
    // Clock
    input  wire logic              mclk,
    // Write port
    input  wire logic              wr_en,
    input  wire logic [IDX_W-1:0]  wr_idx,
    input  wire logic [DATA_W-1:0] wr_data,
    // Read port
    input  wire logic [IDX_W-1:0]  rd_idx,
    output logic      [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [SETS];

    // Contents have no reset; software fills sets before enabling
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Read port
    assign rd_data = mem[rd_idx];
endmodule // set_store

/* set_sequencer.sv */
// Purpose: Frame trigger driven parameter set sequencer with AXI4-Lite registers
// Assumes: Pins asynchronous to mclk; sets written before the sequencer is enabled
// Notes:   Behaviour
// Behaviour
// - Advance decided only by chosen line level
// - Ascending steps, at most one per trigger
// - Optical or any host line, same behaviour
// - Enabling loads set 0 into active set
// - Advance low keeps active set unchanged
// - Advance high loads next set for acquisition
// - Indices 0 to count minus one, wrap
// - Disabling stops cycling, restores prior values
// - Frame trigger sampled on rising edge
// - Line change briefly drops waiting status
// - Trigger outside waiting status is ignored
// - Restart line differs from advance line
// - Restart high loads set 0
// - Restart high overrides advance line
// - Restart low leaves decision to advance
`timescale 1ns/1ps
module set_sequencer #(
    parameter int DATA_W = 32,
    parameter int SETS   = 64
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // AXI4-Lite write channels
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Pins
    input  wire logic              frame_trig_pin,
    input  wire logic              opt_line_pin,
    input  wire logic              host_ctrl_line_a,
    input  wire logic              host_ctrl_line_b,
    input  wire logic              host_ctrl_line_c,
    // Acquisition side
    output logic                   waiting_trigger,
    output logic                   expose_start,
    output logic [DATA_W-1:0]      active_params,
    output logic [$clog2(SETS)-1:0] active_index
);
    localparam int IDX_W = $clog2(SETS);
    localparam int CNT_W = IDX_W + 1;
    localparam int BSY_W = $clog2(seq_pkg::SETTLE_CYC + 1);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Ascending step with wrap after the last valid index
    function automatic logic [IDX_W-1:0] step_index(input logic [IDX_W-1:0] cur,
                                                    input logic [CNT_W-1:0] cnt);
        logic [CNT_W-1:0] nxt;
        nxt = {1'b0, cur} + CNT_W'(1);
        return (nxt >= cnt) ? '0 : nxt[IDX_W-1:0];
    endfunction

    // Byte lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) res[b*8 +: 8] = nw[b*8 +: 8];
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [seq_pkg::CTRL_W-1:0] ctrl, next_ctrl;
    logic [CNT_W-1:0]           set_count, next_set_count;
    logic [DATA_W-1:0]          base_val, next_base_val;
    logic [IDX_W-1:0]           set_sel, next_set_sel;
    logic                       aw_hold, next_aw_hold, w_hold, next_w_hold;
    logic [7:0]                 aw_addr, next_aw_addr;
    logic [31:0]                w_data, next_w_data;
    logic [3:0]                 w_be, next_w_be;
    logic                       next_bvalid, next_rvalid;
    logic [1:0]                 next_bresp, next_rresp;
    logic [31:0]                next_rdata;
    logic                       mem_we;
    logic [DATA_W-1:0]          mem_wdata;
    logic                       aw_have, w_have, do_write;
    logic [7:0]                 wa;
    logic [31:0]                wd;
    logic [3:0]                 wb;

    assign awready = !aw_hold && !bvalid;
    assign wready  = !w_hold && !bvalid;
    assign arready = !rvalid;
    assign aw_have = aw_hold || (awvalid && awready);
    assign w_have  = w_hold || (wvalid && wready);
    assign do_write = aw_have && w_have;
    assign wa = aw_hold ? aw_addr : awaddr;
    assign wd = w_hold ? w_data : wdata;
    assign wb = w_hold ? w_be : wstrb;

    // Register slave: address and data in either order, answer after both
    always_comb begin
        next_ctrl      = ctrl;
        next_set_count = set_count;
        next_base_val  = base_val;
        next_set_sel   = set_sel;
        next_aw_hold   = aw_hold;
        next_aw_addr   = aw_addr;
        next_w_hold    = w_hold;
        next_w_data    = w_data;
        next_w_be      = w_be;
        next_bvalid    = bvalid && !bready;
        next_bresp     = bresp;
        next_rvalid    = rvalid && !rready;
        next_rresp     = rresp;
        next_rdata     = rdata;
        mem_we         = 1'b0;
        mem_wdata      = DATA_W'(merge(32'h0000_0000, wd, wb));
        if (awvalid && awready) begin
            next_aw_hold = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_hold = 1'b1;
            next_w_data = wdata;
            next_w_be   = wstrb;
        end
        if (do_write) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = seq_pkg::RESP_OKAY;
            case (wa)
                seq_pkg::ADDR_CTRL:
                    next_ctrl = seq_pkg::CTRL_W'(merge(32'(ctrl), wd, wb));
                seq_pkg::ADDR_COUNT:
                    next_set_count = CNT_W'(merge(32'(set_count), wd, wb));
                seq_pkg::ADDR_BASE:
                    next_base_val = DATA_W'(merge(32'(base_val), wd, wb));
                seq_pkg::ADDR_SET_SEL:
                    next_set_sel = IDX_W'(merge(32'(set_sel), wd, wb));
                seq_pkg::ADDR_SET_DATA:
                    mem_we = 1'b1;
                seq_pkg::ADDR_STATUS, seq_pkg::ADDR_ACTIVE: ;
                default:
                    next_bresp = seq_pkg::RESP_SLVERR;
            endcase
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = seq_pkg::RESP_OKAY;
            case (araddr)
                seq_pkg::ADDR_CTRL:    next_rdata = 32'(ctrl);
                seq_pkg::ADDR_COUNT:   next_rdata = 32'(set_count);
                seq_pkg::ADDR_BASE:    next_rdata = 32'(base_val);
                seq_pkg::ADDR_SET_SEL: next_rdata = 32'(set_sel);
                seq_pkg::ADDR_ACTIVE:  next_rdata = 32'(active_params);
                seq_pkg::ADDR_STATUS:
                    next_rdata = (32'(active_index) << seq_pkg::STAT_IDX_LSB)
                               | 32'(waiting_trigger);
                seq_pkg::ADDR_SET_DATA: next_rdata = 32'h0000_0000;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = seq_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl      <= seq_pkg::CTRL_RST;
            set_count <= CNT_W'(seq_pkg::COUNT_RST);
            base_val  <= '0;
            set_sel   <= '0;
            aw_hold   <= 1'b0;
            aw_addr   <= 8'h00;
            w_hold    <= 1'b0;
            w_data    <= 32'h0000_0000;
            w_be      <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= seq_pkg::RESP_OKAY;
            rvalid    <= 1'b0;
            rresp     <= seq_pkg::RESP_OKAY;
            rdata     <= 32'h0000_0000;
        end else begin
            ctrl      <= next_ctrl;
            set_count <= next_set_count;
            base_val  <= next_base_val;
            set_sel   <= next_set_sel;
            aw_hold   <= next_aw_hold;
            aw_addr   <= next_aw_addr;
            w_hold    <= next_w_hold;
            w_data    <= next_w_data;
            w_be      <= next_w_be;
            bvalid    <= next_bvalid;
            bresp     <= next_bresp;
            rvalid    <= next_rvalid;
            rresp     <= next_rresp;
            rdata     <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronising and line selection
    // ----------------------------------------------------------------
    logic [seq_pkg::PIN_N-1:0] lvl, chg;
    logic [1:0]                adv_src, rst_src;
    logic [3:0]                inv_mask, line_lvl;
    logic                      seq_en, adv_lvl, rst_lvl, rst_used, sel_change, trig_edge;

    line_sync #(.WIDTH(seq_pkg::PIN_N)) u_sync (
        .mclk   (mclk),
        .rst    (rst),
        .pins   ({frame_trig_pin, host_ctrl_line_c, host_ctrl_line_b,
                  host_ctrl_line_a, opt_line_pin}),
        .level  (lvl),
        .change (chg)
    );

    assign seq_en   = ctrl[seq_pkg::CTRL_EN_BIT];
    assign adv_src  = ctrl[seq_pkg::CTRL_ADV_LSB +: 2];
    assign rst_src  = ctrl[seq_pkg::CTRL_RST_LSB +: 2];
    assign inv_mask = ctrl[seq_pkg::CTRL_INV_LSB +: 4];
    assign line_lvl = lvl[3:0] ^ inv_mask;
    assign adv_lvl  = line_lvl[adv_src];
    // A restart source equal to the advance source is not honoured
    assign rst_used = ctrl[seq_pkg::CTRL_REN_BIT] && (rst_src != adv_src);
    assign rst_lvl  = rst_used && line_lvl[rst_src];
    assign sel_change = chg[adv_src] || (rst_used && chg[rst_src]);
    assign trig_edge  = chg[seq_pkg::PIN_TRIG] && lvl[seq_pkg::PIN_TRIG];

    // ----------------------------------------------------------------
    // Sequencer core
    // ----------------------------------------------------------------
    logic [BSY_W-1:0]  busy_cnt, next_busy_cnt;
    logic              en_prev, next_waiting, next_expose, take, en_rise;
    logic [IDX_W-1:0]  next_index, rd_idx;
    logic [DATA_W-1:0] next_params, set_data;

    set_store #(.DATA_W(DATA_W), .SETS(SETS), .IDX_W(IDX_W)) u_store (
        .mclk    (mclk),
        .wr_en   (mem_we),
        .wr_idx  (set_sel),
        .wr_data (mem_wdata),
        .rd_idx  (rd_idx),
        .rd_data (set_data)
    );

    assign take    = trig_edge && waiting_trigger;
    assign en_rise = seq_en && !en_prev;

    // Choose the set to load; restart wins over advance
    always_comb begin
        rd_idx = active_index;
        if (en_rise) begin
            rd_idx = '0;
        end else if (take && rst_lvl) begin
            rd_idx = '0;
        end else if (take && adv_lvl) begin
            rd_idx = step_index(active_index, set_count);
        end
    end

    // Active set, settle window and exposure pulse
    always_comb begin
        next_busy_cnt = (busy_cnt != '0) ? busy_cnt - BSY_W'(1) : busy_cnt;
        if (sel_change) begin
            next_busy_cnt = BSY_W'(seq_pkg::SETTLE_CYC);
        end
        next_waiting = (next_busy_cnt == '0);
        // Exposure starts in the same cycle as the load lands
        next_expose  = take;
        if (!seq_en) begin
            next_index  = '0;
            next_params = base_val;
        end else begin
            next_index  = rd_idx;
            next_params = set_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_cnt        <= '0;
            waiting_trigger <= 1'b1;
            expose_start    <= 1'b0;
            en_prev         <= 1'b0;
            active_index    <= '0;
            active_params   <= '0;
        end else begin
            busy_cnt        <= next_busy_cnt;
            waiting_trigger <= next_waiting;
            expose_start    <= next_expose;
            en_prev         <= seq_en;
            active_index    <= next_index;
            active_params   <= next_params;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_take_hold;
        take && seq_en && !en_rise && !rst_lvl && !adv_lvl;
    endsequence
    sequence s_take_step;
        take && seq_en && !en_rise && !rst_lvl && adv_lvl;
    endsequence
    sequence s_take_restart;
        take && seq_en && !en_rise && rst_lvl;
    endsequence

    a_enable_load_zero: assert property (en_rise |=> active_index == '0)
        else $error("enable did not load set zero");
    a_low_holds_set: assert property (s_take_hold |=> $stable(active_index))
        else $error("set changed with advance line low");
    a_high_steps_set: assert property (s_take_step
        |=> active_index == step_index($past(active_index), set_count))
        else $error("advance did not step to next set");
    a_restart_wins: assert property (s_take_restart |=> active_index == '0)
        else $error("restart did not load set zero");
    a_ignore_busy: assert property (trig_edge && !waiting_trigger && seq_en && !en_rise
        |=> $stable(active_index) && !expose_start)
        else $error("trigger taken outside waiting status");
    a_change_drops_wait: assert property (sel_change |=> !waiting_trigger [*8])
        else $error("waiting status kept during line change");
    a_disable_reverts: assert property (!seq_en |=> active_params == $past(base_val))
        else $error("active set not restored while disabled");
    a_load_before_expose: assert property (take |=> expose_start
        && active_params == $past(next_params))
        else $error("exposure started before set load");
    a_index_in_range: assert property (seq_en && !en_rise && set_count != '0
        && {1'b0, $past(active_index)} < set_count |-> {1'b0, active_index} < set_count)
        else $error("set index left valid range");
endmodule // set_sequencer

/* frame_source.sv */
// Purpose: External controller model driving trigger and lines
// Assumes: Levels 0..3 map to optical, host a, host b, host c
// Notes:   An early frame fires before the lines settle
`timescale 1ns/1ps
module frame_source (
    // Clock and status
    input  wire logic mclk,
    input  wire logic waiting_trigger,
    // Pins
    output logic       frame_trig_pin,
    output logic [3:0] line_pins
);
    initial begin
        frame_trig_pin = 1'b0;
        line_pins = 4'h0;
    end

    // One frame: set levels, settle, trigger, hold
    task automatic frame(input logic [3:0] lv, input bit early);
        int n;
        @(posedge mclk);
        line_pins <= lv;
        repeat (early ? 6 : 30) @(posedge mclk);
        n = 0;
        while (!early && waiting_trigger !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        frame_trig_pin <= 1'b1;
        repeat (30) @(posedge mclk);
        frame_trig_pin <= 1'b0;
        repeat (30) @(posedge mclk);
    endtask
endmodule // frame_source

/* tb.sv */
// Purpose: Self-checking bench for the set sequencer
// Assumes: Frame source model drives trigger and control lines
// Notes:   Expected set per frame is queued, matched at expose_start
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
    // Bus and pins
    logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, base, e_p, c;
    logic [3:0]  wstrb, lv;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        waiting_trigger, expose_start, frame_trig_pin;
    logic [31:0] active_params;
    logic [5:0]  active_index, idx, e_i;
    logic [3:0]  line_pins;
    logic [31:0] set_data [6];
    logic [5:0]  exp_idx [$];
    logic [31:0] exp_par [$];
    int          failures, cmp_count, seed, s, k;
    logic        adv, rs, inv;

    set_sequencer dut_u (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .frame_trig_pin(frame_trig_pin),
        .opt_line_pin(line_pins[0]), .host_ctrl_line_a(line_pins[1]),
        .host_ctrl_line_b(line_pins[2]), .host_ctrl_line_c(line_pins[3]),
        .waiting_trigger(waiting_trigger), .expose_start(expose_start),
        .active_params(active_params), .active_index(active_index));
    frame_source drv_u (.mclk(mclk), .waiting_trigger(waiting_trigger),
        .frame_trig_pin(frame_trig_pin), .line_pins(line_pins));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Bus write; ready is looked at mid-cycle, where it is settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, bv;
        logic [1:0] br;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            bv = bvalid;
            br = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (bv !== 1'b1);
        bready <= 1'b0;
        `CHK(br, seq_pkg::RESP_OKAY)
    endtask

    // Bus read with comparison of data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, rv;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge mclk);
            ta = arvalid && arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge mclk);
            if (ta) arvalid <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
        `CHK(d, ed)
        `CHK(r, er)
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Result monitor: each exposure takes the oldest expectation
    always @(posedge mclk) begin
        if (!rst && expose_start === 1'b1) begin
            if (exp_idx.size() == 0) begin
                `CHK(expose_start, 1'b0)
            end else begin
                e_i = exp_idx.pop_front();
                e_p = exp_par.pop_front();
                `CHK(active_index, e_i)
                `CHK(active_params, e_p)
            end
        end
    end

    // Hang guard, far beyond the expected run length
    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        finish_test();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = '0;
        wstrb = 4'hF;
        failures = 0;
        cmp_count = 0;
        seed = 32'hE88C67CE;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(seq_pkg::ADDR_COUNT, 32'h6, seq_pkg::RESP_OKAY);
        rd(8'h40, 32'h0, seq_pkg::RESP_SLVERR);
        for (k = 0; k < 6; k++) begin
            set_data[k] = $random(seed);
            wr(seq_pkg::ADDR_SET_SEL, 32'(k));
            wr(seq_pkg::ADDR_SET_DATA, set_data[k]);
        end
        base = $random(seed);
        wr(seq_pkg::ADDR_BASE, base);
        // Every advance source, restart on the next line along
        for (s = 0; s < 4; s++) begin
            inv = (s == 2);
            c = 32'h21;
            c[2:1] = 2'(s);
            c[4:3] = 2'(s + 1);
            c[8 + s] = inv;
            wr(seq_pkg::ADDR_CTRL, c);
            repeat (3) @(negedge mclk);
            `CHK(active_params, set_data[0])
            // Status shows waiting with set zero loaded
            rd(seq_pkg::ADDR_STATUS, 32'h1, seq_pkg::RESP_OKAY);
            idx = 6'h0;
            for (k = 0; k < 12; k++) begin
                adv = (k < 9) ? (k != 0 && k != 5) : 1'($random(seed));
                rs = (k == 9);
                if (rs) adv = 1'b1;
                lv = 4'h0;
                lv[s] = adv ^ inv;
                lv[(s + 1) % 4] = rs;
                if (rs) idx = 6'h0;
                else if (adv) idx = (idx == 6'h5) ? 6'h0 : idx + 6'h1;
                exp_idx.push_back(idx);
                exp_par.push_back(set_data[idx]);
                drv_u.frame(lv, 1'b0);
            end
            // Active word read back must match the last loaded set
            rd(seq_pkg::ADDR_ACTIVE, set_data[idx], seq_pkg::RESP_OKAY);
            // Trigger fired while the line is still settling
            lv[s] = ~lv[s];
            drv_u.frame(lv, 1'b1);
            wr(seq_pkg::ADDR_CTRL, 32'h0);
            repeat (3) @(negedge mclk);
            `CHK(active_params, base)
        end
        `CHK(exp_idx.size(), 0)
        finish_test();
    end
endmodule // tb
